// >>> rtl/oplnk_consts.vh
// constants for the operation data link sequencer
// assumes it is included by bare name from the design files
`ifndef OPLNK_CONSTS_VH
`define OPLNK_CONSTS_VH
// register byte addresses
`define OPLNK_A_CTRL 12'h000
`define OPLNK_A_STAT 12'h004
`define OPLNK_A_DSLO 12'h008
`define OPLNK_A_DSHI 12'h00c
`define OPLNK_A_LOFS 12'h010
`define OPLNK_A_EIDX 12'h014
`define OPLNK_A_ECTL 12'h018
`define OPLNK_A_EARE 12'h01c
`define OPLNK_A_EVLA 12'h020
`define OPLNK_A_EVLB 12'h024
`define OPLNK_A_EVHA 12'h028
`define OPLNK_A_EVHB 12'h02c
// reset values
`define OPLNK_CTRL_RST 32'h00000001
`define OPLNK_DSLO_RST 32'h03020100
`define OPLNK_DSHI_RST 32'h07060504
`define OPLNK_ENT_RST 32'h00000400
`define OPLNK_EVA_RST 32'h00001000
`define OPLNK_EVB_RST 32'h00000000
// control bits
`define OPLNK_C_DSTART 0
`define OPLNK_C_LOEN 1
`define OPLNK_C_HIEN 2
// entry word fields
`define OPLNK_E_LINK 1:0
`define OPLNK_E_NEXT 10:2
`define OPLNK_E_DLY 26:11
`define OPLNK_E_LEND 27
`define OPLNK_E_LCNT 31:28
// event word fields
`define OPLNK_V_LINK 1:0
`define OPLNK_V_NEXT 12:4
`define OPLNK_V_TYPE 19:16
`define OPLNK_V_SEL 28:24
`define OPLNK_V_DWELL 15:0
`define OPLNK_V_COUNT 31:16
// link modes
`define OPLNK_LK_NONE 2'h0
`define OPLNK_LK_MAN 2'h1
`define OPLNK_LK_AUTO 2'h2
`define OPLNK_LK_CONT 2'h3
// next entry codes
`define OPLNK_NX_STOP 9'h100
`define OPLNK_NX_P1 9'h1ff
`define OPLNK_NX_P2 9'h1fe
// trigger types
`define OPLNK_T_NONE 4'h0
`define OPLNK_T_ONCC 4'h1
`define OPLNK_T_ON 4'h2
`define OPLNK_T_OFFCC 4'h3
`define OPLNK_T_OFF 4'h4
`define OPLNK_T_RISE 4'h5
`define OPLNK_T_FALL 4'h6
`define OPLNK_T_ONC 4'h7
`define OPLNK_T_OFFC 4'h8
// timing
`define OPLNK_CLK_NS 5
`define OPLNK_TICK_NS 1000000
`endif

// >>> rtl/oplnk_area.v
// area window comparator for the running entry
// assumes position and window settings are stable synchronous values
`timescale 1ns/1ps
`default_nettype none
module oplnk_area (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [31:0] i_pos,
  input wire [15:0] i_ofs,
  input wire [15:0] i_wid,
  input wire i_en,
  output reg o_area
);
  // one extra bit so the upper bound cannot wrap
  wire signed [32:0] pos_s = {i_pos[31], i_pos};
  wire signed [32:0] lo_s = {{17{i_ofs[15]}}, i_ofs};
  wire signed [32:0] hi_s = lo_s + $signed({17'h00000, i_wid});
  // window is [offset, offset+width); zero width means no area
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_area <= 1'b0;
    else
      o_area <= i_en & (pos_s >= lo_s) & (pos_s < hi_s);
  end
endmodule
`default_nettype wire

// >>> rtl/oplnk_evt.v
// one operation event trigger detector
// assumes a one-cycle millisecond tick and a one-cycle arm pulse per motion start
`timescale 1ns/1ps
`include "oplnk_consts.vh"
`default_nettype none
module oplnk_evt (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_tick,
  input wire i_arm,
  input wire i_en,
  input wire i_sig,
  input wire [3:0] i_type,
  input wire [15:0] i_count,
  output reg o_hit
);
  reg sig_d_r; // last sample, for edges
  reg [16:0] cnt_r; // ms or edge count
  reg fired_r; // one hit per motion
  wire is_on = (i_type == `OPLNK_T_ON) | (i_type == `OPLNK_T_ONCC) | (i_type == `OPLNK_T_ONC);
  wire is_off = (i_type == `OPLNK_T_OFF) | (i_type == `OPLNK_T_OFFCC) | (i_type == `OPLNK_T_OFFC);
  wire plain = (i_type == `OPLNK_T_ON) | (i_type == `OPLNK_T_OFF);
  wire keep = (i_type == `OPLNK_T_ONC) | (i_type == `OPLNK_T_OFFC);
  wire is_edge = (i_type == `OPLNK_T_RISE) | (i_type == `OPLNK_T_FALL);
  wire cond = (is_on & i_sig) | (is_off & ~i_sig);
  wire edg = ((i_type == `OPLNK_T_RISE) & i_sig & ~sig_d_r) |
             ((i_type == `OPLNK_T_FALL) & ~i_sig & sig_d_r);
  // an edge count of zero still needs one edge
  wire [16:0] thr = (is_edge & (i_count == 16'h0000)) ? 17'h00001 : {1'b0, i_count};
  wire met = is_edge ? (cnt_r >= thr) : (cond & (cnt_r >= thr));
  // counting: plain time restarts when the level drops, cumulative kinds hold
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sig_d_r <= 1'b0;
      cnt_r <= 17'h00000;
      fired_r <= 1'b0;
      o_hit <= 1'b0;
    end
    else
    begin
      sig_d_r <= i_sig;
      o_hit <= 1'b0;
      if (i_arm)
      begin
        fired_r <= 1'b0;
        // true cumulative totals survive motion starts
        if (!keep)
          cnt_r <= 17'h00000;
      end
      else if (plain & ~cond)
        cnt_r <= 17'h00000;
      else if (cnt_r != 17'h1ffff)
      begin
        if ((is_edge & edg) | (~is_edge & cond & i_tick))
          cnt_r <= cnt_r + 17'h00001;
      end
      if (!i_arm && i_en && !fired_r && met)
      begin
        o_hit <= 1'b1;
        fired_r <= 1'b1;
        if (keep)
          cnt_r <= 17'h00000;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/oplnk_seq.v
// operation data link sequencer: entry select, linking and event jumps
// assumes an outside profile generator that runs one entry per start pulse,
// reports seg_end when a target is reached and done when the motor stops
//
// What this block does
// R1 - no link: run one entry, then stop
// R2 - manual: sequential start launches next while ready
// R3 - automatic: after stop, wait delay, start next
// R4 - continuous: launch next while still moving
// R5 - per-entry area offset and width drive area
// R6 - loop only with count, offset, end marker
// R7 - events enabled when configured; high event wins
// R8 - event link codes 0..3, reset none
// R9 - next field stop, +1, +2, absolute; reset stop
// R10 - dwell wait in milliseconds after event
// R11 - trigger source selectable; zero means none
// R12 - trigger types: none, times, edges
// R13 - trigger count: ms or detections
// R14 - event with no link is ignored
// R15 - manual event: stop, dwell, ready, wait start
// R16 - automatic event: stop, dwell, launch next
// R17 - continuous event: switch entry while moving
// R18 - direct select beats binary select
// R19 - each direct input has its own entry parameter
// R20 - none or several direct inputs: use binary
// R21 - binary inputs form entry, bit0 least
// R22 - drive-start picks select only or select+start
// R23 - ready drops at start, returns at completion
// R24 - out-of-range next entry means stop
`timescale 1ns/1ps
`include "oplnk_consts.vh"
`default_nettype none
module oplnk_seq #(
  parameter MS_CYC = `OPLNK_TICK_NS / `OPLNK_CLK_NS
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [11:0] i_paddr,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [7:0] i_direct_select_inputs,
  input wire [7:0] i_entry_select_inputs,
  input wire i_start,
  input wire i_sequential_start_input,
  input wire i_mot_seg_end,
  input wire i_mot_done,
  input wire [31:0] i_cmd_pos,
  input wire [31:0] i_int_out,
  output reg o_ready,
  output reg o_mot_start,
  output reg o_mot_stop,
  output reg o_mot_cont,
  output reg [7:0] o_mot_entry,
  output wire o_motion_area_output
);
  // sequencer states, one-hot
  localparam [4:0] S_IDLE = 5'h01; // ready, nothing pending
  localparam [4:0] S_RUN = 5'h02; // entry running
  localparam [4:0] S_STOP = 5'h04; // event decel in progress
  localparam [4:0] S_DLY = 5'h08; // delay or dwell count
  localparam [4:0] S_WAIT = 5'h10; // ready, next entry pending
  localparam integer MS_LAST_I = MS_CYC - 1;
  localparam [17:0] MS_LAST = MS_LAST_I[17:0]; // tick period fits 18 bits

  // register file
  reg [31:0] ctrl_r; // drive-start and event enables
  reg [31:0] dslo_r; // direct entries 0..3
  reg [31:0] dshi_r; // direct entries 4..7
  reg [31:0] lofs_r; // loop offset value
  reg lofs_set_r; // loop offset written since reset
  reg [7:0] eidx_r; // entry table pointer
  reg [31:0] ent_mem [0:255]; // link, next, delay, loop
  reg [31:0] are_mem [0:255]; // area width:offset
  reg [31:0] evla_r; // low event mode word
  reg [31:0] evlb_r; // low event dwell/count
  reg [31:0] evha_r; // high event mode word
  reg [31:0] evhb_r; // high event dwell/count
  // sequencer
  reg [4:0] state_r;
  reg [8:0] pend_nx_r; // pending target, bit8 = stop
  reg [1:0] pend_lk_r; // link mode that set the delay
  reg [15:0] dly_r; // remaining ms
  reg loop_act_r; // loop armed
  reg [7:0] loop_st_r; // loop start entry
  reg [3:0] loop_rem_r; // passes still to run
  // input history for edges
  reg start_d_r;
  reg sst_d_r;
  reg [7:0] dsel_d_r;
  // millisecond tick
  reg [17:0] tick_cnt_r;
  reg tick_r;
  integer k; // direct select scan
  integer j; // table reset sweep, kept apart from the scan

  // resolve a next-entry code against the current entry
  function [8:0] nx_res;
    input [7:0] cur;
    input [8:0] code;
    reg [9:0] sum;
    begin
      sum = 10'h000;
      if (code == `OPLNK_NX_P1)
        sum = {2'b00, cur} + 10'h001; // R9
      else if (code == `OPLNK_NX_P2)
        sum = {2'b00, cur} + 10'h002; // R9
      else if (!code[8])
        sum = {2'b00, code[7:0]}; // R9
      else
        sum = 10'h100; // R9 R24
      // walking past entry 255 also stops
      nx_res = (sum[9] | sum[8]) ? `OPLNK_NX_STOP : {1'b0, sum[7:0]}; // R24
    end
  endfunction

  // entry selection: direct inputs only count when exactly one is on
  wire [7:0] ds = i_direct_select_inputs;
  wire ds_one = (ds != 8'h00) & ((ds & (ds - 8'h01)) == 8'h00); // R20
  reg [7:0] ds_ent;
  always @*
  begin
    ds_ent = 8'h00;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (ds[k])
        ds_ent = (k < 4) ? dslo_r[k*8 +: 8] : dshi_r[(k-4)*8 +: 8]; // R19
    end
  end
  wire [7:0] sel_ent = ds_one ? ds_ent : i_entry_select_inputs; // R18 R21
  wire ds_rise = ds_one & (ds != dsel_d_r);
  // a fresh direct press starts only with drive-start set
  wire start_req = (i_start & ~start_d_r) |
                   (ds_rise & ctrl_r[`OPLNK_C_DSTART]); // R22
  wire sst_rise = i_sequential_start_input & ~sst_d_r;

  // current entry fields
  wire [31:0] ent = ent_mem[o_mot_entry];
  wire [31:0] are = are_mem[o_mot_entry];
  wire [1:0] ent_lk = ent[`OPLNK_E_LINK];
  wire loop_back = loop_act_r & ent[`OPLNK_E_LEND] & (loop_rem_r != 4'h0);
  wire [8:0] comp_tgt = loop_back ? {1'b0, loop_st_r} :
                        nx_res(o_mot_entry, ent[`OPLNK_E_NEXT]);

  // event sources; selector zero is no function
  wire [4:0] lsel = evla_r[`OPLNK_V_SEL];
  wire [4:0] hsel = evha_r[`OPLNK_V_SEL];
  wire lsig = (lsel != 5'h00) & i_int_out[lsel]; // R11
  wire hsig = (hsel != 5'h00) & i_int_out[hsel]; // R11
  wire run = (state_r == S_RUN);
  wire lo_hit;
  wire hi_hit;
  oplnk_evt u_evt_lo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(tick_r),
    .i_arm(o_mot_start),
    .i_en(run & ctrl_r[`OPLNK_C_LOEN] & (lsel != 5'h00)), // R7
    .i_sig(lsig),
    .i_type(evla_r[`OPLNK_V_TYPE]), // R12
    .i_count(evlb_r[`OPLNK_V_COUNT]), // R13
    .o_hit(lo_hit)
  );
  oplnk_evt u_evt_hi (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(tick_r),
    .i_arm(o_mot_start),
    .i_en(run & ctrl_r[`OPLNK_C_HIEN] & (hsel != 5'h00)), // R7
    .i_sig(hsig),
    .i_type(evha_r[`OPLNK_V_TYPE]), // R12
    .i_count(evhb_r[`OPLNK_V_COUNT]), // R13
    .o_hit(hi_hit)
  );
  // the high event wins a tie
  wire [31:0] ev_a = hi_hit ? evha_r : evla_r; // R7
  wire [31:0] ev_b = hi_hit ? evhb_r : evlb_r; // R7
  wire [1:0] ev_lk = ev_a[`OPLNK_V_LINK];
  wire ev_take = (hi_hit | lo_hit) & (ev_lk != `OPLNK_LK_NONE); // R14

  oplnk_area u_area (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pos(i_cmd_pos),
    .i_ofs(are[15:0]), // R5
    .i_wid(are[31:16]), // R5
    .i_en(~state_r[0]),
    .o_area(o_motion_area_output)
  );

  // free running millisecond tick
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      tick_cnt_r <= 18'h00000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == MS_LAST);
      tick_cnt_r <= (tick_cnt_r == MS_LAST) ? 18'h00000 : tick_cnt_r + 18'h00001;
    end
  end

  // apb read mux, registered one cycle into the access phase
  reg [31:0] rd_val;
  reg rd_err;
  always @*
  begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (i_paddr)
      `OPLNK_A_CTRL: rd_val = ctrl_r;
      `OPLNK_A_STAT: rd_val = {12'h000, state_r[3:0], o_mot_entry, 7'h00, o_ready};
      `OPLNK_A_DSLO: rd_val = dslo_r;
      `OPLNK_A_DSHI: rd_val = dshi_r;
      `OPLNK_A_LOFS: rd_val = lofs_r;
      `OPLNK_A_EIDX: rd_val = {24'h000000, eidx_r};
      `OPLNK_A_ECTL: rd_val = ent_mem[eidx_r];
      `OPLNK_A_EARE: rd_val = are_mem[eidx_r];
      `OPLNK_A_EVLA: rd_val = evla_r;
      `OPLNK_A_EVLB: rd_val = evlb_r;
      `OPLNK_A_EVHA: rd_val = evha_r;
      `OPLNK_A_EVHB: rd_val = evhb_r;
      default: rd_err = 1'b1; // unmapped: zero data, error
    endcase
  end

  wire acc = i_psel & i_penable & ~o_pready;
  wire wr = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  // bus handshake and register writes
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      ctrl_r <= `OPLNK_CTRL_RST; // R22
      dslo_r <= `OPLNK_DSLO_RST; // R19
      dshi_r <= `OPLNK_DSHI_RST; // R19
      lofs_r <= 32'h00000000;
      lofs_set_r <= 1'b0;
      eidx_r <= 8'h00;
      evla_r <= `OPLNK_EVA_RST; // R8 R9 R11 R12
      evlb_r <= `OPLNK_EVB_RST; // R10 R13
      evha_r <= `OPLNK_EVA_RST; // R8 R9 R11 R12
      evhb_r <= `OPLNK_EVB_RST; // R10 R13
      for (j = 0; j < 256; j = j + 1)
      begin
        ent_mem[j] <= `OPLNK_ENT_RST; // R9
        are_mem[j] <= 32'h00000000;
      end
    end
    else
    begin
      o_pready <= acc;
      o_pslverr <= acc & rd_err;
      o_prdata <= (acc & ~i_pwrite) ? rd_val : 32'h00000000;
      if (wr)
      begin
        case (i_paddr)
          `OPLNK_A_CTRL: ctrl_r <= {29'h00000000, i_pwdata[2:0]};
          `OPLNK_A_DSLO: dslo_r <= i_pwdata;
          `OPLNK_A_DSHI: dshi_r <= i_pwdata;
          `OPLNK_A_LOFS:
          begin
            lofs_r <= i_pwdata;
            lofs_set_r <= 1'b1; // R6
          end
          `OPLNK_A_EIDX: eidx_r <= i_pwdata[7:0];
          `OPLNK_A_ECTL: ent_mem[eidx_r] <= i_pwdata;
          `OPLNK_A_EARE: are_mem[eidx_r] <= i_pwdata;
          `OPLNK_A_EVLA: evla_r <= i_pwdata & 32'h1f0f1ff3;
          `OPLNK_A_EVLB: evlb_r <= i_pwdata;
          `OPLNK_A_EVHA: evha_r <= i_pwdata & 32'h1f0f1ff3;
          `OPLNK_A_EVHB: evhb_r <= i_pwdata;
          default: ctrl_r <= ctrl_r; // read-only or unmapped
        endcase
      end
    end
  end

  // start a target entry, or fall back to idle when it means stop
  task launch;
    input [8:0] tgt;
    input cont;
    begin
      if (tgt[8])
      begin
        state_r <= S_IDLE; // R24
        o_ready <= 1'b1;
      end
      else
      begin
        state_r <= S_RUN;
        o_mot_entry <= tgt[7:0];
        o_mot_start <= 1'b1;
        o_mot_cont <= cont;
        o_ready <= 1'b0; // R23
        // a loop arms only when count and offset are set; the end marker is needed only to loop back
        if (!loop_act_r && lofs_set_r && (ent_mem[tgt[7:0]][`OPLNK_E_LCNT] != 4'h0))
        begin
          loop_act_r <= 1'b1; // R6
          loop_st_r <= tgt[7:0];
          loop_rem_r <= ent_mem[tgt[7:0]][`OPLNK_E_LCNT] - 4'h1;
        end
      end
    end
  endtask

  // loop bookkeeping when the current entry completes
  task loop_step;
    begin
      if (loop_back)
        loop_rem_r <= loop_rem_r - 4'h1; // R6
      else if (ent[`OPLNK_E_LEND])
        loop_act_r <= 1'b0; // R6
    end
  endtask

  // link sequencer
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_r <= S_IDLE;
      o_ready <= 1'b1;
      o_mot_start <= 1'b0;
      o_mot_stop <= 1'b0;
      o_mot_cont <= 1'b0;
      o_mot_entry <= 8'h00;
      pend_nx_r <= `OPLNK_NX_STOP;
      pend_lk_r <= `OPLNK_LK_NONE;
      dly_r <= 16'h0000;
      loop_act_r <= 1'b0;
      loop_st_r <= 8'h00;
      loop_rem_r <= 4'h0;
      start_d_r <= 1'b0;
      sst_d_r <= 1'b0;
      dsel_d_r <= 8'h00;
    end
    else
    begin
      start_d_r <= i_start;
      sst_d_r <= i_sequential_start_input;
      dsel_d_r <= ds;
      o_mot_start <= 1'b0;
      o_mot_stop <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          // sequential start has nothing to run here and is ignored
          if (start_req)
            launch({1'b0, sel_ent}, 1'b0);
        end
        S_RUN:
        begin
          if (ev_take)
          begin
            pend_nx_r <= nx_res(o_mot_entry, ev_a[`OPLNK_V_NEXT]);
            dly_r <= ev_b[`OPLNK_V_DWELL]; // R10
            pend_lk_r <= ev_lk;
            if (ev_lk == `OPLNK_LK_CONT)
              launch(nx_res(o_mot_entry, ev_a[`OPLNK_V_NEXT]), 1'b1); // R17
            else
            begin
              o_mot_stop <= 1'b1; // R15 R16
              state_r <= S_STOP;
            end
          end
          else if (ent_lk == `OPLNK_LK_CONT && (i_mot_seg_end || i_mot_done))
          begin
            loop_step;
            launch(comp_tgt, i_mot_seg_end); // R4
          end
          else if (i_mot_done)
          begin
            loop_step;
            pend_nx_r <= comp_tgt;
            pend_lk_r <= ent_lk;
            dly_r <= ent[`OPLNK_E_DLY];
            if (ent_lk == `OPLNK_LK_NONE)
            begin
              state_r <= S_IDLE; // R1
              o_ready <= 1'b1; // R23
            end
            else if (ent_lk == `OPLNK_LK_MAN)
            begin
              state_r <= S_WAIT; // R2
              o_ready <= 1'b1; // R23
            end
            else
              state_r <= S_DLY; // R3
          end
        end
        S_STOP:
        begin
          // decel requested; dwell starts once the motor has stopped
          if (i_mot_done)
            state_r <= S_DLY;
        end
        S_DLY:
        begin
          if (dly_r == 16'h0000)
          begin
            if (pend_lk_r == `OPLNK_LK_MAN)
            begin
              state_r <= S_WAIT; // R15
              o_ready <= 1'b1;
            end
            else
              launch(pend_nx_r, 1'b0); // R3 R16
          end
          else if (tick_r)
            dly_r <= dly_r - 16'h0001; // R10
        end
        S_WAIT:
        begin
          // sequential start is honoured only while ready is shown
          if (sst_rise)
            launch(pend_nx_r, 1'b0); // R2 R15
          else if (start_req)
            launch({1'b0, sel_ent}, 1'b0);
        end
        default:
        begin
          state_r <= S_IDLE;
          o_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> sim/oplnk_motor.sv
// motion generator model standing at the sequencer's far side
// assumes at most one start or stop request at a time
`timescale 1ns/1ps
`default_nettype none
module oplnk_motor #(
  parameter int RUN = 60
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_cont,
  input wire logic i_seg,
  output logic o_done,
  output logic o_seg_end
);
  int cnt; // cycles left in the present motion
  // run timer; a stop request cuts the run down to a short deceleration
  always @(posedge i_sys_clk)
  begin
    o_done <= 1'b0;
    o_seg_end <= 1'b0;
    if (i_rst)
      cnt <= 0;
    else if (i_stop)
      cnt <= 3;
    else if (i_start)
      cnt <= RUN;
    else if (cnt == 1)
    begin
      cnt <= 0;
      // with seg set, a run not launched as continuous reports a segment end, not a stop
      if (i_seg && !i_cont)
        o_seg_end <= 1'b1;
      else
        o_done <= 1'b1;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// >>> sim/oplnk_seq_monitor.sv
// port checker for the link sequencer
// assumes one clock domain with a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module oplnk_seq_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_start,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_ready,
  input wire logic o_mot_start,
  input wire logic o_mot_stop,
  input wire logic o_mot_cont
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // every access has exactly one wait state
  bus_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  bus_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  err_rdy_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("prdata not idle");
  start_busy_a: assert property (o_mot_start |-> !o_ready)
    else $error("ready high at launch");
  ready_drop_a: assert property ($fell(o_ready) |-> o_mot_start)
    else $error("ready fell without launch");
  stop_busy_a: assert property (o_mot_stop |-> !o_ready ##1 !o_ready)
    else $error("ready high while stopping");
  // a start edge while ready launches on the very next cycle
  start_resp_a: assert property ($rose(i_start) && o_ready |=> o_mot_start)
    else $error("start not taken");
  cont_launch_a: assert property ($rose(o_mot_cont) |-> o_mot_start)
    else $error("cont without launch");
endmodule
bind oplnk_seq oplnk_seq_monitor mon (.i_sys_clk, .i_rst, .i_psel, .i_penable, .i_start,
  .o_prdata, .o_pready, .o_pslverr, .o_ready, .o_mot_start, .o_mot_stop, .o_mot_cont);
`default_nettype wire

// >>> sim/oplnk_seq_test.sv
// self-checking bench for the link sequencer
// assumes the motion model and the checker are compiled alongside
`timescale 1ns/1ps
`include "oplnk_consts.vh"
`default_nettype none
module oplnk_seq_test;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic st = 1'b0, sst = 1'b0, seg = 1'b0, area_exp = 1'b0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, pos = 32'h0, io = 32'h0;
  logic [7:0] dsel = 8'h0, msel = 8'h0;
  wire logic [31:0] prd;
  wire logic [7:0] ment;
  wire logic prdy, perr, rdy, mst, msp, mct, done, sege, area;
  logic [31:0] exp_q[$]; // expected read words and launched entries, oldest first
  int num_errors = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  // positions kept to 16 bits so the area window is hit often
  always @(posedge clk) pos <= $urandom & 32'h0000ffff;
  // a short millisecond keeps delay and dwell counts cheap
  oplnk_seq #(.MS_CYC(10)) dut (.i_sys_clk(clk), .i_rst(rst), .i_paddr(pa), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .i_direct_select_inputs(dsel), .i_entry_select_inputs(msel),
    .i_start(st), .i_sequential_start_input(sst), .i_mot_seg_end(sege), .i_mot_done(done),
    .i_cmd_pos(pos), .i_int_out(io), .o_ready(rdy), .o_mot_start(mst), .o_mot_stop(msp),
    .o_mot_cont(mct), .o_mot_entry(ment), .o_motion_area_output(area));
  oplnk_motor mot (.i_sys_clk(clk), .i_rst(rst), .i_start(mst), .i_stop(msp), .i_cont(mct),
    .i_seg(seg), .o_done(done), .o_seg_end(sege));
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] v);
    logic [31:0] e;
    e = 32'hffffffff; // an empty queue means nothing was due
    if (exp_q.size() != 0)
      e = exp_q.pop_front();
    checks_done++;
    if (v !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, v);
    end
  endtask
  // watcher: read data at pready, entry at every launch
  always @(posedge clk)
  begin
    if (prdy && !pwr)
      chk("prdata", prd);
    if (mst)
      chk("entry", {24'h0, ment});
    if (prdy && perr !== (pa > `OPLNK_A_EVHB))
    begin
      num_errors++;
      $display("unexpected pslverr expected %b seen %b", pa > `OPLNK_A_EVHB, perr);
    end
    if (!rst)
      checks_done++;
    if (!rst && area !== area_exp)
    begin
      num_errors++;
      $display("unexpected area expected %b seen %b", area_exp, area);
    end
    // only entry 0 has a window, live while the sequencer is busy
    area_exp <= !rdy && ment == 8'h00 && pos >= 32'h4000 && pos < 32'h8000;
  end
  // one bus transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pa <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk) pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 50);
    if (prdy !== 1'b1)
    begin
      num_errors++;
      $display("unexpected pready expected 1 seen %b", prdy);
    end
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge so back-to-back calls never drive psel twice in a step
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task ent(input logic [7:0] i, input logic [31:0] w);
    apb(1'b1, `OPLNK_A_EIDX, {24'h0, i});
    apb(1'b1, `OPLNK_A_ECTL, w);
  endtask
  // wait, bounded, for ready with nothing left outstanding
  task settle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while ((rdy !== 1'b1 || exp_q.size() != 0) && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
    begin
      num_errors++;
      $display("unexpected ready expected 1 seen %b", rdy);
    end
    repeat (2) @(posedge clk);
  endtask
  // start request; the launch is noted ahead of any follow-on entries already queued
  task go(input logic [7:0] d, input logic [7:0] m, input logic [7:0] e);
    dsel <= d;
    msel <= m;
    exp_q.push_front({24'h0, e});
    @(posedge clk) st <= 1'b1;
    @(posedge clk)
    begin
      st <= 1'b0;
      dsel <= 8'h0;
    end
    settle;
  endtask
  // second pulse follows five cycles later and must launch nothing
  task ss;
    sst <= 1'b1;
    @(posedge clk) sst <= 1'b0;
    repeat (5) @(posedge clk);
    sst <= 1'b1;
    @(posedge clk) sst <= 1'b0;
    settle;
  endtask
  // run entry 0 and raise trigger bit 3 in mid-motion
  task ev(input logic k, input logic [7:0] n);
    if (k)
      exp_q.push_back({24'h0, n});
    fork
      go(8'h0, 8'h0, 8'h0);
      begin
        repeat (10) @(posedge clk);
        io <= 32'h8;
      end
    join
    io <= 32'h0;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    $display("unexpected watchdog expected done seen hang");
    close_out;
  end
  initial
  begin
    logic [63:0] map;
    logic [7:0] m;
    void'($urandom(32'h119e));
    map = {$urandom, $urandom};
    m = $urandom;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`OPLNK_A_CTRL, `OPLNK_CTRL_RST);
    rd(`OPLNK_A_DSLO, `OPLNK_DSLO_RST);
    rd(`OPLNK_A_DSHI, `OPLNK_DSHI_RST);
    rd(`OPLNK_A_STAT, 32'h00010001);
    rd(`OPLNK_A_ECTL, `OPLNK_ENT_RST);
    rd(`OPLNK_A_EVLA, `OPLNK_EVA_RST);
    rd(`OPLNK_A_EVLB, 32'h0);
    rd(12'h030, 32'h0);
    apb(1'b1, `OPLNK_A_EARE, 32'h40004000);
    apb(1'b1, `OPLNK_A_DSLO, map[31:0]);
    apb(1'b1, `OPLNK_A_DSHI, map[63:32]);
    for (int i = 0; i < 8; i++)
      go(8'h1 << i, m, map[8*i +: 8]);
    go(8'h03, m, m);
    go(8'h00, m ^ 8'h5a, m ^ 8'h5a);
    apb(1'b1, `OPLNK_A_CTRL, 32'h0);
    go(8'h10, m, map[39:32]);
    ent(20, 32'h000007fd);
    ent(30, 32'h00000401);
    ent(40, 32'h000010ca);
    ent(60, 32'h000007fb);
    rd(`OPLNK_A_ECTL, 32'h000007fb);
    go(8'h00, 8'd20, 8'd20);
    exp_q.push_back(32'd21);
    ss;
    go(8'h00, 8'd30, 8'd30);
    ss;
    exp_q.push_back(32'd50);
    go(8'h00, 8'd40, 8'd40);
    seg <= 1'b1;
    exp_q.push_back(32'd62);
    go(8'h00, 8'd60, 8'd60);
    seg <= 1'b0;
    apb(1'b1, `OPLNK_A_LOFS, 32'h1);
    ent(90, 32'h200007fe);
    ent(91, 32'h08000402);
    exp_q.push_back(32'd91);
    exp_q.push_back(32'd90);
    exp_q.push_back(32'd91);
    go(8'h00, 8'd90, 8'd90);
    apb(1'b1, `OPLNK_A_EVLA, 32'h03050462);
    apb(1'b1, `OPLNK_A_EVLB, 32'h00010001);
    apb(1'b1, `OPLNK_A_EVHA, 32'h03050503);
    apb(1'b1, `OPLNK_A_EVHB, 32'h00010001);
    apb(1'b1, `OPLNK_A_CTRL, 32'h7);
    ev(1'b1, 8'd80);
    apb(1'b1, `OPLNK_A_CTRL, 32'h3);
    ev(1'b1, 8'd70);
    apb(1'b1, `OPLNK_A_EVLA, 32'h03050460);
    ev(1'b0, 8'd0);
    close_out;
  end
endmodule
`default_nettype wire
